/* hw/iq_test_gen_check.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - while transmit test is on, the selected pattern drives the data outputs continuously
// - transmit offers three patterns: pseudo-random, ascending counter, sampled sine
// - pseudo-random pattern is the 16-stage sequence, same on I and Q
// - output follows configured word size; sequence leaves in consecutive word-size pieces for sizes 1 to 16
// - counter pattern outputs ascending binary numbers, same on I and Q
// - transmit counter steps once per data clock, lsb toggling at clock rate
// - sine samples are scaled to the range of the configured word size
// - sine Q channel is offset by 90 degrees from I channel
// - output starts when transmit test switches on, stops when switched off
// - receive test compares incoming words with internal references, counting bit errors
// - receive checker supports only pseudo-random and counter references
// - counter check expects the received word to increase by one each data clock
// - pseudo-random check expects the 16-stage sequence from the far party
// - checker counts received words and reports an error ratio from bit errors
// - pseudo-random checker locks onto stream; unlocked ratio sits near one half
module iq_test_gen_check (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        DCLK,
   input  wire logic [17:0] RX_I,
   input  wire logic [17:0] RX_Q,
   output logic      [17:0] TX_I,
   output logic      [17:0] TX_Q,
   output logic             TX_OE,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [5:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   output logic             IRQ
);
   localparam int W = iq_test_pkg::DATA_W;

   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      lfsr_step = {s[14:0], ^(s & iq_test_pkg::LFSR_TAPS)};
   endfunction

   function automatic logic [17:0] word_mask(input logic [4:0] ws);
      logic [4:0] n;
      n = (ws > 5'(W)) ? 5'(W) : ((ws < iq_test_pkg::WSIZE_MIN) ? iq_test_pkg::WSIZE_MIN : ws);
      word_mask = 18'((19'h00001 << n) - 19'h00001);
   endfunction

   function automatic logic [4:0] ones(input logic [17:0] v);
      logic [4:0] c;
      c = 5'h00;
      for (int k = 0; k < W; k++) begin
         c = c + 5'(v[k]);
      end
      ones = c;
   endfunction

   // quarter sine table, 16 entries, 15-bit amplitude
   function automatic logic [16:0] qsin(input logic [3:0] a);
      case (a)
         4'h0: qsin = 17'h00000;  4'h1: qsin = 17'h0C8B;  4'h2: qsin = 17'h18F9;
         4'h3: qsin = 17'h2528;   4'h4: qsin = 17'h30FB;  4'h5: qsin = 17'h3C56;
         4'h6: qsin = 17'h471C;   4'h7: qsin = 17'h5133;  4'h8: qsin = 17'h5A82;
         4'h9: qsin = 17'h62F1;   4'hA: qsin = 17'h6A6D;  4'hB: qsin = 17'h70E2;
         4'hC: qsin = 17'h7641;   4'hD: qsin = 17'h7A7C;  4'hE: qsin = 17'h7D89;
         default: qsin = 17'h7F61;
      endcase
   endfunction

   // 64-step signed sine scaled to word size
   function automatic logic [17:0] sine(input logic [5:0] ph, input logic [4:0] ws);
      logic [3:0]  a;
      logic [16:0] m;
      logic [17:0] v;
      logic [4:0]  n;
      a = ph[4] ? ~ph[3:0] : ph[3:0];
      m = qsin(a);
      v = ph[5] ? 18'(-{2'b00, m[15:0]}) : {2'b00, m[15:0]};
      n = (ws > 5'(W)) ? 5'(W) : ((ws < iq_test_pkg::WSIZE_MIN) ? iq_test_pkg::WSIZE_MIN : ws);
      sine = 18'($signed(v) >>> (5'd17 - (n > 5'd17 ? 5'd17 : n))) & word_mask(ws);
   endfunction

   // link clock and data sync
   logic [2:0]  dclk_q, dclk_d;
   logic [17:0] ri1_q, ri2_q, rq1_q, rq2_q;
   logic        tick;
   always_comb begin
      dclk_d = {dclk_q[1:0], DCLK};
   end
   assign tick = dclk_q[1] & ~dclk_q[2];
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         dclk_q <= 3'h0;
         ri1_q  <= 18'h00000;
         ri2_q  <= 18'h00000;
         rq1_q  <= 18'h00000;
         rq2_q  <= 18'h00000;
      end else begin
         dclk_q <= dclk_d;
         ri1_q  <= RX_I;
         ri2_q  <= ri1_q;
         rq1_q  <= RX_Q;
         rq2_q  <= rq1_q;
      end
   end

   // registers
   logic [31:0] ctrl_q, ctrl_d;
   logic [3:0]  ist_q, ist_d, imask_q, imask_d;
   logic [31:0] rdat_q, rdat_d;
   logic        ack_q, ack_d, irq_q, irq_d;
   logic        acc;
   logic        tx_en, rx_en;
   logic [1:0]  pat;
   logic [4:0]  ws;
   logic [3:0]  ev;
   assign tx_en = ctrl_q[iq_test_pkg::TX_EN_BIT];
   assign rx_en = ctrl_q[iq_test_pkg::RX_EN_BIT];
   assign pat   = ctrl_q[iq_test_pkg::PAT_LSB +: 2];
   assign ws    = ctrl_q[iq_test_pkg::WSIZE_LSB +: 5];
   assign acc   = WB_CYC_I & WB_STB_I & ~ack_q;

   // transmit state
   logic [15:0] tl_q, tl_d;
   logic [17:0] cnt_q, cnt_d, txi_q, txi_d, txq_q, txq_d;
   logic [5:0]  ph_q, ph_d;
   logic        oe_q, oe_d;
   always_comb begin
      tl_d  = tl_q;
      cnt_d = cnt_q;
      ph_d  = ph_q;
      txi_d = txi_q;
      txq_d = txq_q;
      oe_d  = tx_en;
      if (!tx_en) begin
         tl_d  = iq_test_pkg::LFSR_SEED;
         cnt_d = 18'h00000;
         ph_d  = 6'h00;
         txi_d = 18'h00000;
         txq_d = 18'h00000;
      end else if (tick) begin
         case (pat)
            iq_test_pkg::PAT_PRBS: begin
               // one new bit per word bit, lsb newest
               for (int k = 0; k < W; k++) begin
                  if (5'(k) < ws) begin
                     tl_d = lfsr_step(tl_d);
                  end
               end
               txi_d = {2'b00, tl_d} & word_mask(ws);
               txq_d = {2'b00, tl_d} & word_mask(ws);
            end
            iq_test_pkg::PAT_COUNT: begin
               cnt_d = cnt_q + 18'h00001;
               txi_d = cnt_q & word_mask(ws);
               txq_d = cnt_q & word_mask(ws);
            end
            iq_test_pkg::PAT_SINE: begin
               ph_d  = ph_q + 6'h01;
               txi_d = sine(ph_q, ws);
               txq_d = sine(6'(ph_q + 6'h10), ws);
            end
            default: begin
               txi_d = 18'h00000;
               txq_d = 18'h00000;
            end
         endcase
      end
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tl_q  <= iq_test_pkg::LFSR_SEED;
         cnt_q <= 18'h00000;
         ph_q  <= 6'h00;
         txi_q <= 18'h00000;
         txq_q <= 18'h00000;
         oe_q  <= 1'b0;
      end else begin
         tl_q  <= tl_d;
         cnt_q <= cnt_d;
         ph_q  <= ph_d;
         txi_q <= txi_d;
         txq_q <= txq_d;
         oe_q  <= oe_d;
      end
   end

   // receive checker
   iq_test_pkg::rx_state_t st_q, st_d;
   logic [15:0] rl_q, rl_d;
   logic [35:0] exp_q, exp_d;
   logic        have_q, have_d, rx_en_q, rx_en_d;
   logic [4:0]  sc_q, sc_d;
   logic [7:0]  bad_q, bad_d;
   logic [31:0] words_q, words_d, errs_q, errs_d;
   logic [17:0] m, ref_word, diff;
   logic [5:0]  nerr;
   logic [15:0] pl;
   always_comb begin
      st_d    = st_q;
      rl_d    = rl_q;
      exp_d   = exp_q;
      have_d  = have_q;
      sc_d    = sc_q;
      bad_d   = bad_q;
      words_d = words_q;
      errs_d  = errs_q;
      rx_en_d = rx_en;
      ev      = 4'h0;
      m       = word_mask(ws);
      ref_word = 18'h00000;
      diff    = 18'h00000;
      nerr    = 6'h00;
      pl      = rl_q;
      if (rx_en && !rx_en_q) begin
         words_d = 32'h00000000;
         errs_d  = 32'h00000000;
         st_d    = iq_test_pkg::RX_HUNT;
         have_d  = 1'b0;
         sc_d    = 5'h00;
         bad_d   = 8'h00;
      end else if (rx_en && tick) begin
         if (words_d != 32'hFFFFFFFF) begin
            words_d = words_q + 32'h00000001;
         end
         if (pat == iq_test_pkg::PAT_COUNT) begin
            ref_word = exp_q[17:0] & m;
            exp_d = {18'(rq2_q + 18'h00001), 18'(ri2_q + 18'h00001)};
            have_d = 1'b1;
            diff = have_q ? ((ri2_q ^ ref_word) | (rq2_q ^ exp_q[35:18])) & m : 18'h00000;
            nerr = 6'(ones((ri2_q ^ ref_word) & m)) + 6'(ones((rq2_q ^ exp_q[35:18]) & m));
            if (!have_q) begin
               nerr = 6'h00;
            end
         end else begin
            // predict next word bit by bit from own register
            for (int k = 0; k < W; k++) begin
               if (5'(k) < ws) begin
                  pl = lfsr_step(pl);
               end
            end
            ref_word = {2'b00, pl} & m;
            if (st_q == iq_test_pkg::RX_HUNT) begin
               // load received bits into reference register, oldest first
               for (int k = W - 1; k >= 0; k--) begin
                  if (5'(k) < ws) begin
                     rl_d = {rl_d[14:0], ri2_q[k]};
                  end
               end
               // unlocked: compare anyway, about half the bits mismatch
               nerr = 6'(ones((ri2_q ^ ref_word) & m)) + 6'(ones((rq2_q ^ ref_word) & m));
               if (((ri2_q ^ ref_word) & m) == 18'h00000) begin
                  sc_d = sc_q + 5'h01;
               end else begin
                  sc_d = 5'h00;
               end
               if (sc_d >= iq_test_pkg::SYNC_LOAD) begin
                  st_d  = iq_test_pkg::RX_LOCK;
                  bad_d = 8'h00;
                  ev[iq_test_pkg::IRQ_LOCK] = 1'b1;
               end
            end else begin
               rl_d = pl;
               diff = (ri2_q ^ ref_word) & m;
               nerr = 6'(ones(diff)) + 6'(ones((rq2_q ^ ref_word) & m));
               if (diff != 18'h00000) begin
                  bad_d = (bad_q == 8'hFF) ? bad_q : bad_q + 8'h01;
               end else begin
                  bad_d = 8'h00;
               end
               if (bad_d >= iq_test_pkg::SYNC_LOSS) begin
                  st_d = iq_test_pkg::RX_HUNT;
                  sc_d = 5'h00;
                  ev[iq_test_pkg::IRQ_LOSS] = 1'b1;
               end
            end
         end
         if (nerr != 6'h00) begin
            ev[iq_test_pkg::IRQ_ERR] = 1'b1;
            if (errs_q > 32'hFFFFFFFF - 32'(nerr)) begin
               errs_d = 32'hFFFFFFFF;
               ev[iq_test_pkg::IRQ_SAT] = 1'b1;
            end else begin
               errs_d = errs_q + 32'(nerr);
            end
         end
      end
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q    <= iq_test_pkg::RX_HUNT;
         rl_q    <= iq_test_pkg::LFSR_SEED;
         exp_q   <= 36'h000000000;
         have_q  <= 1'b0;
         sc_q    <= 5'h00;
         bad_q   <= 8'h00;
         words_q <= 32'h00000000;
         errs_q  <= 32'h00000000;
         rx_en_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         rl_q    <= rl_d;
         exp_q   <= exp_d;
         have_q  <= have_d;
         sc_q    <= sc_d;
         bad_q   <= bad_d;
         words_q <= words_d;
         errs_q  <= errs_d;
         rx_en_q <= rx_en_d;
      end
   end

   // error ratio: errors / (2 * words * size), Q0.16
   logic [15:0] ratio_q, ratio_d;
   logic [47:0] den;
   logic [47:0] num;
   always_comb begin
      den = 48'(words_q) * 48'({ws, 1'b0});
      num = {errs_q, 16'h0000};
      ratio_d = ratio_q;
      if (den != 48'h0) begin
         ratio_d = (num / den > 48'h0FFFF) ? 16'hFFFF : 16'(num / den);
      end else begin
         ratio_d = 16'h0000;
      end
   end

   // bus slave
   always_comb begin
      ctrl_d  = ctrl_q;
      imask_d = imask_q;
      ist_d   = ist_q;
      rdat_d  = 32'h00000000;
      ack_d   = acc;
      if (acc && WB_WE_I) begin
         if (WB_ADR_I[5:2] == iq_test_pkg::CTRL_OFF) begin
            if (WB_SEL_I[0]) begin
               ctrl_d[7:0] = WB_DAT_I[7:0];
            end
            if (WB_SEL_I[1]) begin
               ctrl_d[8] = WB_DAT_I[8];
            end
         end else if (WB_ADR_I[5:2] == iq_test_pkg::IRQ_MASK_OFF) begin
            if (WB_SEL_I[0]) begin
               imask_d = WB_DAT_I[3:0];
            end
         end
      end else if (acc) begin
         if (WB_ADR_I[5:2] == iq_test_pkg::CTRL_OFF) begin
            rdat_d = {23'h000000, ctrl_q[8:0]};
         end else if (WB_ADR_I[5:2] == iq_test_pkg::STATUS_OFF) begin
            rdat_d = {30'h00000000, oe_q, st_q == iq_test_pkg::RX_LOCK};
         end else if (WB_ADR_I[5:2] == iq_test_pkg::IRQ_STAT_OFF) begin
            rdat_d = {28'h0000000, ist_q};
            ist_d  = 4'h0;
         end else if (WB_ADR_I[5:2] == iq_test_pkg::IRQ_MASK_OFF) begin
            rdat_d = {28'h0000000, imask_q};
         end else if (WB_ADR_I[5:2] == iq_test_pkg::WORDS_OFF) begin
            rdat_d = words_q;
         end else if (WB_ADR_I[5:2] == iq_test_pkg::ERRS_OFF) begin
            rdat_d = errs_q;
         end else if (WB_ADR_I[5:2] == iq_test_pkg::RATIO_OFF) begin
            rdat_d = {16'h0000, ratio_q};
         end
      end
      ist_d = ist_d | ev;
      irq_d = |(ist_d & imask_d);
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_q  <= {23'h000000, iq_test_pkg::WSIZE_RST, 4'h0};
         imask_q <= 4'h0;
         ist_q   <= 4'h0;
         rdat_q  <= 32'h00000000;
         ack_q   <= 1'b0;
         irq_q   <= 1'b0;
         ratio_q <= 16'h0000;
      end else begin
         ctrl_q  <= ctrl_d;
         imask_q <= imask_d;
         ist_q   <= ist_d;
         rdat_q  <= rdat_d;
         ack_q   <= ack_d;
         irq_q   <= irq_d;
         ratio_q <= ratio_d;
      end
   end

   assign TX_I     = txi_q;
   assign TX_Q     = txq_q;
   assign TX_OE    = oe_q;
   assign WB_DAT_O = rdat_q;
   assign WB_ACK_O = ack_q;
   assign IRQ      = irq_q;
endmodule

/* hw/iq_test_pkg.sv */
package iq_test_pkg;
   // register word offsets, address bits 5:2
   localparam logic [3:0] CTRL_OFF      = 4'h0;
   localparam logic [3:0] STATUS_OFF    = 4'h1;
   localparam logic [3:0] IRQ_STAT_OFF  = 4'h2;
   localparam logic [3:0] IRQ_MASK_OFF  = 4'h3;
   localparam logic [3:0] WORDS_OFF     = 4'h4;
   localparam logic [3:0] ERRS_OFF      = 4'h5;
   localparam logic [3:0] RATIO_OFF     = 4'h6;
   // control fields
   localparam int TX_EN_BIT   = 0;
   localparam int RX_EN_BIT   = 1;
   localparam int PAT_LSB     = 2;
   localparam int WSIZE_LSB   = 4;
   localparam int DATA_W      = 18;
   localparam logic [4:0] WSIZE_RST = 5'h10;
   localparam logic [4:0] WSIZE_MIN = 5'h01;
   // lfsr x^16+x^14+x^13+x^11+1
   localparam logic [15:0] LFSR_TAPS = 16'hB400;
   localparam logic [15:0] LFSR_SEED = 16'hFFFF;
   localparam logic [4:0]  SYNC_LOAD = 5'h10;
   localparam logic [7:0]  SYNC_LOSS = 8'h40;
   localparam logic [5:0]  SINE_STEPS = 6'h3F;
   typedef enum logic [1:0] {PAT_PRBS, PAT_COUNT, PAT_SINE, PAT_RSVD} pat_t;
   typedef enum {RX_HUNT, RX_LOCK} rx_state_t;
   localparam int IRQ_LOCK  = 0;
   localparam int IRQ_LOSS  = 1;
   localparam int IRQ_ERR   = 2;
   localparam int IRQ_SAT   = 3;
endpackage

/* tb/iq_test_gen_check_sva.sv */
`timescale 1ns/1ps
module iq_test_gen_check_sva (
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic        DCLK,
   input wire logic [17:0] RX_I,
   input wire logic [17:0] RX_Q,
   input wire logic [17:0] TX_I,
   input wire logic [17:0] TX_Q,
   input wire logic        TX_OE,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [5:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        IRQ
);
   logic [31:0] ctrl_q;
   logic [3:0]  mask_q;
   logic [4:0]  age_q;
   logic        wr_q;
   logic [17:0] wmask;
   logic        take;
   logic        settled;
   assign take = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
   assign settled = age_q == 5'h1F;
   assign wmask = (ctrl_q[8:4] >= 5'h12) ? 18'h3FFFF : (18'h00001 << ctrl_q[8:4]) - 18'h00001;
   // shadow of control and mask, age since last control write
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_q <= 32'h00000100;
         mask_q <= 4'h0;
         age_q  <= 5'h00;
         wr_q   <= 1'b0;
      end else begin
         wr_q <= take && WB_ADR_I[5:2] == 4'h0;
         age_q <= (take && WB_ADR_I[5:2] == 4'h0) ? 5'h00 : age_q + {4'h0, !settled};
         if (take && WB_ADR_I[5:2] == 4'h0) ctrl_q <= WB_DAT_I;
         if (take && WB_ADR_I[5:2] == 4'h3) mask_q <= WB_DAT_I[3:0];
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   chk_ack_one: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("ack is not a single pulse one cycle after the request");
   chk_iq_equal: assert property (settled && TX_OE && ctrl_q[3:2] != 2'h2 |-> TX_I == TX_Q)
      else $error("I and Q words differ outside sine");
   chk_ws_upper: assert property (settled && TX_OE |-> ((TX_I | TX_Q) & ~wmask) == 18'h0)
      else $error("bits above word size set");
   chk_count_step: assert property (settled && TX_OE && ctrl_q[3:2] == 2'h1 && $changed(TX_I)
      |-> TX_I == (($past(TX_I) + 18'h1) & wmask))
      else $error("counter did not step by one");
   chk_tx_stands: assert property (settled && TX_OE && $changed(TX_I) |=> (!settled || $stable(TX_I))[*8])
      else $error("transmit word changed twice within one data clock");
   chk_tx_follow: assert property (wr_q |-> ##[1:3] TX_OE == ctrl_q[0])
      else $error("output enable did not follow control");
   chk_tx_hold: assert property (settled |-> TX_OE == ctrl_q[0])
      else $error("output enable dropped while transmit on");
   chk_irq_masked: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !IRQ)
      else $error("interrupt high with all sources masked");
   cov_count: cover property (settled && TX_OE && ctrl_q[3:2] == 2'h1);
   cov_sine: cover property (settled && TX_OE && ctrl_q[3:2] == 2'h2);
   cov_irq: cover property ($rose(IRQ));
endmodule
bind iq_test_gen_check iq_test_gen_check_sva chk (.CLK(CLK), .RST_N(RST_N), .DCLK(DCLK), .RX_I(RX_I),
   .RX_Q(RX_Q), .TX_I(TX_I), .TX_Q(TX_Q), .TX_OE(TX_OE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ));

/* tb/iq_far_end.sv */
`timescale 1ns/1ps
module iq_far_end (
   input  wire logic        run,
   input  wire logic        flip,
   input  wire logic        loop,
   input  wire logic [17:0] tx_i,
   output logic             dclk,
   output logic [17:0]      rx_i,
   output logic [17:0]      rx_q
);
   logic [17:0] cnt = 18'h00000;
   initial dclk = 1'b0;
   initial rx_i = 18'h00000;
   initial rx_q = 18'h00000;
   // clock stands low between bursts
   always begin
      #62.5;
      if (run || dclk) dclk = ~dclk;
   end
   // data changes mid-word, away from the sampling edge
   always @(negedge dclk) begin
      cnt <= cnt + 18'h00001;
      rx_i <= loop ? tx_i : (cnt + 18'h00001) ^ (flip ? 18'h20000 : 18'h00000);
      rx_q <= loop ? tx_i : cnt + 18'h00001;
   end
endmodule

/* tb/iq_test_gen_check_tb.sv */
`timescale 1ns/1ps
module iq_test_gen_check_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc, stb, we, run, flip, loop, dclk, tx_oe, ack, irq;
   logic [3:0]  sel;
   logic [5:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [17:0] tx_i, tx_q, rx_i, rx_q;
   logic [17:0] wi [0:79];
   logic [17:0] wq [0:79];
   int          failures = 0;
   int          samples_checked = 0;
   int          ticks;
   always #5 clk = ~clk;
   always @(posedge dclk) ticks++;
   iq_test_gen_check dut (.CLK(clk), .RST_N(rst_n), .DCLK(dclk), .RX_I(rx_i), .RX_Q(rx_q), .TX_I(tx_i),
      .TX_Q(tx_q), .TX_OE(tx_oe), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq));
   iq_far_end far (.run(run), .flip(flip), .loop(loop), .tx_i(tx_i), .dclk(dclk), .rx_i(rx_i), .rx_q(rx_q));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wb(input logic w_en, input logic [3:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w_en;
      sel <= 4'hF;
      adr <= {idx, 2'b00};
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 50) begin
         failures++;
         $display("[FAIL] bus ack expected 1 seen %b", ack);
         print_verdict();
      end
   endtask
   task automatic grab(input int n);
      run = 1'b1;
      for (int k = 0; k < n; k++) begin
         @(negedge dclk);
         wi[k] = tx_i;
         wq[k] = tx_q;
      end
      run = 1'b0;
      repeat (20) @(posedge clk);
   endtask
   task automatic burst(input int n, input int f);
      ticks = 0;
      run = 1'b1;
      while (ticks < n) begin
         @(posedge clk);
         flip = (ticks == f);
      end
      run = 1'b0;
      repeat (20) @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      print_verdict();
   end
   initial begin
      {cyc, stb, we, run, flip, loop, sel, adr, wdat} = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      wb(0, 4'h0, 0);
      chk("ctrl reset", 32'h00000100, q);
      wb(0, 4'hF, 0);
      chk("unmapped", 32'h0, q);
      wb(1, 4'h0, 32'h00000045);
      grab(20);
      for (int k = 0; k < 20; k++) begin
         chk("count i", 32'(k & 15), {14'h0, wi[k]});
         chk("count q", 32'(k & 15), {14'h0, wq[k]});
      end
      wb(1, 4'h0, 32'h00000109);
      grab(80);
      for (int k = 0; k < 64; k++) begin
         chk("sine q", {14'h0, wi[k + 16]}, {14'h0, wq[k]});
      end
      loop = 1'b1;
      wb(1, 4'h0, 32'h00000103);
      grab(40);
      for (int k = 0; k < 40; k++) begin
         chk("prbs q", {14'h0, wi[k]}, {14'h0, wq[k]});
      end
      wb(0, 4'h1, 0);
      chk("locked", 32'h3, q);
      loop = 1'b0;
      burst(72, -1);
      wb(0, 4'h1, 0);
      chk("lock lost", 32'h2, q);
      wb(0, 4'h2, 0);
      chk("lock events", 32'h3, q & 32'h3);
      wb(1, 4'h0, 0);
      repeat (3) @(posedge clk);
      chk("oe off", 0, {31'h0, tx_oe});
      chk("tx off", 0, {14'h0, tx_i});
      wb(1, 4'h3, 0);
      wb(1, 4'h0, 32'h00000126);
      burst(40, 20);
      chk("irq masked", 0, {31'h0, irq});
      wb(0, 4'h5, 0);
      chk("bit errors", 32'h2, q);
      wb(0, 4'h4, 0);
      chk("words", 32'd40, q);
      wb(0, 4'h6, 0);
      chk("ratio", 1, {31'h0, q >= 32'd90 && q <= 32'd92});
      wb(1, 4'h3, 32'h00000004);
      repeat (3) @(posedge clk);
      chk("irq on", 1, {31'h0, irq});
      wb(0, 4'h2, 0);
      chk("err event", 32'h4, q & 32'h4);
      repeat (3) @(posedge clk);
      chk("irq off", 0, {31'h0, irq});
      wb(1, 4'h0, 0);
      wb(1, 4'h0, 32'h00000126);
      wb(0, 4'h4, 0);
      chk("words clear", 0, q);
      print_verdict();
   end
endmodule
